//--- hw/sfr_top.sv
// simd fp register state: vector array and control/status word
//
// Overview of operation
// (RULE_01) 64-bit mode exposes eight more vector registers, chosen only by extension prefix.
// (RULE_02) compatibility mode behaves exactly like protected mode.
// (RULE_03) a meaningless extension prefix is ignored, never faults.
// (RULE_04) prefix width bit selects 64-bit general-purpose operands.
// (RULE_05) each vector register is 128 bits of private storage.
// (RULE_06) vector registers never feed address generation.
// (RULE_07) loads and stores move 32, 64 or 128 bits.
// (RULE_08) full store emits 16 bytes, bits 7:0 at lowest address.
// (RULE_09) control word written by load/restore, read by store/save.
// (RULE_10) bits 31:16 reset to zero; nonzero write faults.
// (RULE_11) flags 5:0 are sticky until software writes zero.
// (RULE_12) bits 12:7 mask the matching exceptions.
// (RULE_13) reset sets all six mask bits.
// (RULE_14) unmasking a set flag raises nothing by itself.
// (RULE_15) bits 14:13 pick the rounding mode.
// (RULE_16) flush mode with masked underflow gives signed zero, sets underflow and precision.
// (RULE_17) unmasked underflow ignores the flush bit.
// (RULE_18) reset clears the flush bit.
// (RULE_19) denormal-zero mode turns denormal inputs into signed zeros.
// (RULE_20) in denormal-zero mode the denormal flag and exception never occur.
// (RULE_21) reset clears the denormal-zero bit.
// (RULE_22) without denormal-zero support, setting bit 6 faults.
// (RULE_23) rounding codes: nearest, down, up, toward zero.
// (RULE_24) flag order: invalid, denormal, divzero, overflow, underflow, precision.
`timescale 1ns/1ps
`default_nettype none
module sfr_top #(
   parameter bit HAS_DNZ = 1'b1
) (
   // clock and reset
   input  wire logic                   I_REF_CLK,
   input  wire logic                   I_RESETN,
   // mode and operand selection
   input  wire logic                   I_LONG_MODE,
   input  wire logic                   I_SEL_VALID,
   input  wire logic                   I_EXT_PREFIX,
   input  wire logic                   I_EXT_REG_BIT,
   input  wire logic                   I_EXT_WIDTH_BIT,
   input  wire logic [2:0]             I_MODRM_REG,
   // vector load from memory path
   input  wire logic                   I_VLD_VALID,
   input  wire sfr_pkg::sfr_size_t     I_VLD_SIZE,
   input  wire logic                   I_VLD_HIGH,
   input  wire logic [127:0]           I_VLD_DATA,
   // vector store to memory path
   input  wire logic                   I_VST_VALID,
   input  wire sfr_pkg::sfr_size_t     I_VST_SIZE,
   input  wire logic                   I_VST_HIGH,
   // control word access
   input  wire logic                   I_CSR_LOAD,
   input  wire logic                   I_CSR_RESTORE,
   input  wire logic [31:0]            I_CSR_WDATA,
   input  wire logic                   I_CSR_STORE,
   input  wire logic                   I_CSR_SAVE,
   // exceptions detected by execution, and the result sign
   input  wire logic                   I_EXC_VALID,
   input  wire logic [5:0]             I_EXC_FLAGS,
   input  wire logic                   I_EXC_SIGN,
   // source operand to screen for denormals
   input  wire logic [31:0]            I_SRC_OPND,
   // outputs
   output logic [127:0]                O_VST_DATA,
   output logic [15:0]                 O_VST_BYTE_EN,
   output logic                        O_VST_VALID,
   output logic [31:0]                 O_CSR_RDATA,
   output logic [31:0]                 O_SUPPORTED_MASK,
   output logic                        O_CSR_RVALID,
   output logic                        O_PROT_FAULT,
   output logic                        O_SIMD_EXC,
   output logic                        O_FLUSH_ZERO,
   output logic [31:0]                 O_FLUSHED_RESULT,
   output logic [31:0]                 O_SRC_OPND,
   output logic                        O_GPR_WIDE,
   output var sfr_pkg::sfr_round_t     O_ROUND_MODE,
   output logic [3:0]                  O_VEC_IDX
);
   import sfr_pkg::*;

   typedef struct packed {
      sfr_state_t    st;
      logic [31:0]   csr;
      logic [127:0]  vst_data;
      logic [15:0]   vst_be;
      logic          vst_valid;
      logic [31:0]   rdata;
      logic          rvalid;
      logic          prot;
      logic          sexc;
      logic          flush_hit;
      logic [31:0]   flush_res;
      logic [31:0]   src;
      logic          gpr_wide;
      logic [3:0]    idx;
   } sfr_reg_t;

   sfr_reg_t   r;
   sfr_reg_t   next_r;
   sfr_sel_if  sel ();

   // separate storage, not aliased to any other file
   logic [127:0] vreg [WIDE_REGS]; // RULE_05

   localparam logic [31:0] WMASK = HAS_DNZ ? CSR_WMASK_DNZ : CSR_WMASK_ND;

   // geometry the indexing and byte lanes are built for
   if (VEC_W != 128 || WIDE_REGS != 2 * BASE_REGS || IDX_W != 4) begin : g_geometry_check
      $error("sfr_top: unsupported register geometry");
   end

   sfr_regsel u_regsel (
      .i_long_mode   (I_LONG_MODE),
      .i_valid       (I_SEL_VALID),
      .i_ext_prefix  (I_EXT_PREFIX),
      .i_ext_reg_bit (I_EXT_REG_BIT),
      .i_modrm_reg   (I_MODRM_REG),
      .sel           (sel)
   );

   logic        csr_wr;
   logic [31:0] wr_val;
   logic        wr_bad;
   logic        src_denorm;
   logic [5:0]  exc_eff;
   logic [5:0]  masks;
   logic        flush_apply;

   always_comb begin
      csr_wr = I_CSR_LOAD | I_CSR_RESTORE; // RULE_09
      wr_val = I_CSR_WDATA;
      // reserved high bits, or bit 6 when unsupported, refuse the write
      wr_bad = csr_wr && ((wr_val & ~WMASK) != 32'h0000_0000); // RULE_10 RULE_22
      masks  = r.csr[MASK_MSB:MASK_LSB];
      src_denorm = (I_SRC_OPND[30:23] == 8'h00) && (I_SRC_OPND[22:0] != 23'h000000);
      exc_eff = I_EXC_FLAGS;
      if (r.csr[DNZ_BIT]) begin
         exc_eff[EX_DENORMAL] = 1'b0; // RULE_20
      end
      // flush only when underflow masked
      flush_apply = r.csr[FLUSH_BIT] && masks[EX_UNDERFLOW] && exc_eff[EX_UNDERFLOW]; // RULE_16 RULE_17
      if (flush_apply) begin
         exc_eff[EX_PRECISION] = 1'b1; // RULE_16
      end
   end

   always_comb begin
      next_r = r;
      next_r.vst_valid = 1'b0;
      next_r.rvalid    = 1'b0;
      next_r.prot      = 1'b0;
      next_r.sexc      = 1'b0;
      next_r.flush_hit = 1'b0;
      next_r.gpr_wide  = I_LONG_MODE & I_EXT_PREFIX & I_EXT_WIDTH_BIT; // RULE_04 RULE_03
      next_r.idx       = sel.idx;
      // denormal input replaced by signed zero
      if (r.csr[DNZ_BIT] && src_denorm) begin
         next_r.src = {I_SRC_OPND[31], 31'h0000_0000}; // RULE_19
      end else begin
         next_r.src = I_SRC_OPND;
      end
      case (r.st)
         SFR_ST_IDLE, SFR_ST_WRITE, SFR_ST_FAULT: begin
            next_r.st = SFR_ST_IDLE;
            if (csr_wr && wr_bad) begin
               next_r.prot = 1'b1; // RULE_10 RULE_22
               next_r.st = SFR_ST_FAULT;
            end else if (csr_wr) begin
               // software write replaces flags; no exception from unmasking
               next_r.csr = wr_val & WMASK; // RULE_09 RULE_11 RULE_14
               next_r.st  = SFR_ST_WRITE;
            end
            if (I_EXC_VALID) begin
               // set wins over a simultaneous clearing write
               next_r.csr[FLAG_MSB:FLAG_LSB] = next_r.csr[FLAG_MSB:FLAG_LSB] | exc_eff; // RULE_11 RULE_24
               next_r.sexc = |(exc_eff & ~masks); // RULE_12 RULE_14
               next_r.flush_hit = flush_apply;
               next_r.flush_res = {I_EXC_SIGN, 31'h0000_0000}; // RULE_16
            end
         end
         default: begin
            next_r.st = SFR_ST_IDLE;
         end
      endcase
      if (I_CSR_STORE | I_CSR_SAVE) begin
         next_r.rdata  = r.csr; // RULE_09
         next_r.rvalid = 1'b1;
      end
      // store: register bits 7:0 go to byte 0 (lowest address)
      if (I_VST_VALID) begin
         next_r.vst_valid = 1'b1;
         next_r.vst_data  = vreg[sel.idx]; // RULE_08
         case (I_VST_SIZE)
            SFR_SZ_32:  next_r.vst_be = 16'h000f; // RULE_07
            SFR_SZ_64:  begin
               next_r.vst_be = 16'h00ff;
               if (I_VST_HIGH) begin
                  next_r.vst_data = {64'h0, vreg[sel.idx][127:64]};
               end
            end
            default:    next_r.vst_be = 16'hffff; // RULE_08
         endcase
      end
   end

   always_ff @(posedge I_REF_CLK) begin
      if (!I_RESETN) begin
         r     <= '0;
         r.st  <= SFR_ST_IDLE;
         r.csr <= CSR_RESET; // RULE_10 RULE_13 RULE_18 RULE_21
      end else begin
         r <= next_r;
      end
   end

   // vector file: data only, never an address source
   always_ff @(posedge I_REF_CLK) begin
      if (I_VLD_VALID && sel.valid && sel.legal) begin // RULE_06
         case (I_VLD_SIZE)
            SFR_SZ_32:  vreg[sel.idx][31:0] <= I_VLD_DATA[31:0]; // RULE_07
            SFR_SZ_64:  begin
               if (I_VLD_HIGH) begin
                  vreg[sel.idx][127:64] <= I_VLD_DATA[63:0];
               end else begin
                  vreg[sel.idx][63:0] <= I_VLD_DATA[63:0];
               end
            end
            default:    vreg[sel.idx] <= I_VLD_DATA;
         endcase
      end
   end

   always_comb begin
      O_VST_DATA       = r.vst_data;
      O_VST_BYTE_EN    = r.vst_be;
      O_VST_VALID      = r.vst_valid;
      O_CSR_RDATA      = r.rdata;
      O_CSR_RVALID     = r.rvalid;
      O_PROT_FAULT     = r.prot;
      O_SIMD_EXC       = r.sexc;
      O_FLUSH_ZERO     = r.flush_hit;
      O_FLUSHED_RESULT = r.flush_res;
      O_SRC_OPND       = r.src;
      O_GPR_WIDE       = r.gpr_wide;
      O_ROUND_MODE     = sfr_round_t'(r.csr[RND_MSB:RND_LSB]); // RULE_15 RULE_23
      O_VEC_IDX        = r.idx;
      O_SUPPORTED_MASK = WMASK; // RULE_22
   end

   a_reserved_fault: assert property (@(posedge I_REF_CLK) disable iff (!I_RESETN)
      (I_CSR_LOAD && I_CSR_WDATA[31:16] != 16'h0000) |=> O_PROT_FAULT && $stable(r.csr))
      else $error("reserved write did not fault"); // RULE_10
   a_flag_sticky: assert property (@(posedge I_REF_CLK) disable iff (!I_RESETN)
      (!I_CSR_LOAD && !I_CSR_RESTORE) |=> ((r.csr[5:0] & $past(r.csr[5:0])) == $past(r.csr[5:0])))
      else $error("sticky flag dropped"); // RULE_11
   a_unmask_quiet: assert property (@(posedge I_REF_CLK) disable iff (!I_RESETN)
      !I_EXC_VALID |=> !O_SIMD_EXC)
      else $error("exception without detection"); // RULE_14
   a_dnz_no_flag: assert property (@(posedge I_REF_CLK) disable iff (!I_RESETN)
      (r.csr[6] && I_EXC_VALID && !I_CSR_LOAD && !I_CSR_RESTORE && !r.csr[1]) |=> !r.csr[1])
      else $error("denormal flag set in zeroing mode"); // RULE_20
   a_flush_flags: assert property (@(posedge I_REF_CLK) disable iff (!I_RESETN)
      flush_apply && I_EXC_VALID |=> O_FLUSH_ZERO && r.csr[5] && r.csr[4])
      else $error("flush response wrong"); // RULE_16
   a_flush_unmasked: assert property (@(posedge I_REF_CLK) disable iff (!I_RESETN)
      !masks[4] |=> !O_FLUSH_ZERO)
      else $error("flush with underflow unmasked"); // RULE_17
   a_idx_compat: assert property (@(posedge I_REF_CLK) disable iff (!I_RESETN)
      !I_LONG_MODE |=> !O_VEC_IDX[3])
      else $error("upper register outside 64-bit mode"); // RULE_01
   a_reset_value: assert property (@(posedge I_REF_CLK)
      !I_RESETN |=> r.csr == CSR_RESET)
      else $error("bad reset value"); // RULE_13
   a_store_full: assert property (@(posedge I_REF_CLK) disable iff (!I_RESETN)
      (I_VST_VALID && I_VST_SIZE == SFR_SZ_128) |=> O_VST_BYTE_EN == 16'hffff)
      else $error("full store not 16 bytes"); // RULE_08

   // a refused write with no exception in the same cycle is one fault pulse and leaves the control word alone
   sequence s_refused_write;
      wr_bad && !I_EXC_VALID;
   endsequence
   sequence s_word_kept;
      O_PROT_FAULT && $stable(r.csr);
   endsequence
   a_refuse_any: assert property (@(posedge I_REF_CLK) disable iff (!I_RESETN)
      s_refused_write |=> s_word_kept)
      else $error("refused control word write not held off"); // RULE_10 RULE_22
   a_write_lands: assert property (@(posedge I_REF_CLK) disable iff (!I_RESETN)
      (csr_wr && !wr_bad && !I_EXC_VALID) |=> r.csr == ($past(I_CSR_WDATA) & WMASK))
      else $error("control word write lost"); // RULE_09
   a_gpr_narrow: assert property (@(posedge I_REF_CLK) disable iff (!I_RESETN)
      !(I_LONG_MODE && I_EXT_PREFIX) |=> !O_GPR_WIDE)
      else $error("wide operand without prefix in 64-bit mode"); // RULE_04
   a_store_word: assert property (@(posedge I_REF_CLK) disable iff (!I_RESETN)
      (I_VST_VALID && I_VST_SIZE == SFR_SZ_32) |=> O_VST_BYTE_EN == 16'h000f)
      else $error("word store not 4 bytes"); // RULE_07
   a_store_dword: assert property (@(posedge I_REF_CLK) disable iff (!I_RESETN)
      (I_VST_VALID && I_VST_SIZE == SFR_SZ_64) |=> O_VST_BYTE_EN == 16'h00ff)
      else $error("quadword store not 8 bytes"); // RULE_07
   a_flush_sign: assert property (@(posedge I_REF_CLK) disable iff (!I_RESETN)
      (flush_apply && I_EXC_VALID) |=> O_FLUSHED_RESULT == {$past(I_EXC_SIGN), 31'h0000_0000})
      else $error("flushed zero has wrong sign"); // RULE_16
endmodule
`default_nettype wire

//--- hw/sfr_pkg.sv
// shared constants and types for the simd fp register state block
package sfr_pkg;
   localparam int unsigned VEC_W         = 128;
   localparam int unsigned BASE_REGS     = 8;
   localparam int unsigned WIDE_REGS     = 16;
   localparam int unsigned IDX_W         = 4;
   localparam int unsigned CSR_W         = 32;
   // control/status field positions
   localparam int unsigned FLAG_LSB      = 0;
   localparam int unsigned FLAG_MSB      = 5;
   localparam int unsigned DNZ_BIT       = 6;
   localparam int unsigned MASK_LSB      = 7;
   localparam int unsigned MASK_MSB      = 12;
   localparam int unsigned RND_LSB       = 13;
   localparam int unsigned RND_MSB       = 14;
   localparam int unsigned FLUSH_BIT     = 15;
   localparam int unsigned RSVD_LSB      = 16;
   // exception order within flags and masks
   localparam int unsigned EX_INVALID    = 0;
   localparam int unsigned EX_DENORMAL   = 1;
   localparam int unsigned EX_DIVZERO    = 2;
   localparam int unsigned EX_OVERFLOW   = 3;
   localparam int unsigned EX_UNDERFLOW  = 4;
   localparam int unsigned EX_PRECISION  = 5;
   // reset value: all masks set, everything else clear
   localparam logic [31:0] CSR_RESET     = 32'h0000_1f80;
   // writable bits with and without denormal-zero support
   localparam logic [31:0] CSR_WMASK_DNZ = 32'h0000_ffff;
   localparam logic [31:0] CSR_WMASK_ND  = 32'h0000_ffbf;

   typedef enum logic [1:0] {
      SFR_RND_NEAREST = 2'h0,
      SFR_RND_DOWN    = 2'h1,
      SFR_RND_UP      = 2'h2,
      SFR_RND_ZERO    = 2'h3
   } sfr_round_t;

   typedef enum logic [1:0] {
      SFR_SZ_32  = 2'h0,
      SFR_SZ_64  = 2'h1,
      SFR_SZ_128 = 2'h2
   } sfr_size_t;

   typedef enum logic [2:0] {
      SFR_ST_IDLE  = 3'h1,
      SFR_ST_WRITE = 3'h2,
      SFR_ST_FAULT = 3'h4
   } sfr_state_t;
endpackage

//--- hw/sfr_if.sv
// operand-select carrier between decoder and register array
`timescale 1ns/1ps
`default_nettype none
interface sfr_sel_if;
   logic       valid;
   logic [3:0] idx;
   logic       legal;
   modport dec (output valid, output idx, output legal);
   modport arr (input valid, input idx, input legal);
endinterface
`default_nettype wire

//--- hw/sfr_regsel.sv
// register index decode with extension prefix handling
`timescale 1ns/1ps
`default_nettype none
module sfr_regsel (
   // mode and instruction fields
   input  wire logic       i_long_mode,
   input  wire logic       i_valid,
   input  wire logic       i_ext_prefix,
   input  wire logic       i_ext_reg_bit,
   input  wire logic [2:0] i_modrm_reg,
   // decoded selection
   sfr_sel_if.dec          sel
);
   import sfr_pkg::*;
   // outside long mode (incl. compat) the prefix bit is dropped silently
   always_comb begin
      sel.valid = i_valid;
      sel.idx   = {i_long_mode & i_ext_prefix & i_ext_reg_bit, i_modrm_reg}; // RULE_01 RULE_02 RULE_03
      sel.legal = 1'b1; // RULE_03
   end
endmodule
`default_nettype wire

//--- sim/sfr_mem_model.sv
// data memory model that takes vector stores, byte 0 at lowest address
`timescale 1ns/1ps
`default_nettype none
module sfr_mem_model (
   // clock
   input  wire logic         i_clk,
   // store port from the block
   input  wire logic         i_valid,
   input  wire logic [127:0] i_data,
   input  wire logic [15:0]  i_be,
   // memory image, byte k at bits 8k+7:8k
   output logic [127:0]      o_image
);
   logic [7:0] mem [16];
   initial begin
      for (int k = 0; k < 16; k++) begin
         mem[k] = 8'(k);
      end
   end
   // only enabled bytes change, the rest keep stale contents
   always @(posedge i_clk) begin
      for (int k = 0; k < 16; k++) begin
         if (i_valid && i_be[k]) begin
            mem[k] <= i_data[8*k+:8];
         end
      end
   end
   always_comb begin
      for (int k = 0; k < 16; k++) begin
         o_image[8*k+:8] = mem[k];
      end
   end
endmodule
`default_nettype wire

//--- sim/test_simd_fp_register_state.sv
// self-checking bench for the simd fp register state block
`timescale 1ns/1ps
`default_nettype none
module test_simd_fp_register_state;
   import sfr_pkg::*;
   typedef struct {int k; logic [127:0] v; logic [15:0] b;} sfr_note_t;
   logic         clk;
   logic         rstn = 0, lm = 0, sv = 0, rp = 0, re = 0, rw = 0, lv = 0, lh = 0;
   logic         stv = 0, sh = 0, cl = 0, cr = 0, cs = 0, cv = 0, ev = 0, es = 0;
   logic [2:0]   rl = 0;
   logic [5:0]   ef = 0;
   logic [31:0]  cw = 0, src = 0, crd, smask, fres, sop;
   logic [127:0] ld = 0, vd, img;
   logic [15:0]  vbe;
   logic         vvl, crv, pf, sx, fz, gw;
   logic [3:0]   vidx;
   sfr_size_t    lsz = SFR_SZ_32, ssz = SFR_SZ_32;
   sfr_round_t   rmode;
   sfr_note_t    q[$];
   int           err_total = 0, check_count = 0, cyc = 0;

   sfr_top sfr_top_inst (
      .I_REF_CLK(clk), .I_RESETN(rstn), .I_LONG_MODE(lm), .I_SEL_VALID(sv),
      .I_EXT_PREFIX(rp), .I_EXT_REG_BIT(re), .I_EXT_WIDTH_BIT(rw), .I_MODRM_REG(rl),
      .I_VLD_VALID(lv), .I_VLD_SIZE(lsz), .I_VLD_HIGH(lh), .I_VLD_DATA(ld),
      .I_VST_VALID(stv), .I_VST_SIZE(ssz), .I_VST_HIGH(sh), .I_CSR_LOAD(cl),
      .I_CSR_RESTORE(cr), .I_CSR_WDATA(cw), .I_CSR_STORE(cs), .I_CSR_SAVE(cv),
      .I_EXC_VALID(ev), .I_EXC_FLAGS(ef), .I_EXC_SIGN(es), .I_SRC_OPND(src),
      .O_VST_DATA(vd), .O_VST_BYTE_EN(vbe), .O_VST_VALID(vvl), .O_CSR_RDATA(crd),
      .O_SUPPORTED_MASK(smask), .O_CSR_RVALID(crv), .O_PROT_FAULT(pf), .O_SIMD_EXC(sx),
      .O_FLUSH_ZERO(fz), .O_FLUSHED_RESULT(fres), .O_SRC_OPND(sop), .O_GPR_WIDE(gw),
      .O_ROUND_MODE(rmode), .O_VEC_IDX(vidx)
   );
   sfr_mem_model sfr_mem_model_inst (.i_clk(clk), .i_valid(vvl), .i_data(vd), .i_be(vbe), .o_image(img));

   task automatic tick(int n = 1);
      repeat (n) @(posedge clk);
   endtask
   task automatic summarize();
      $display("checks %0d mismatches %0d", check_count, err_total);
      if (err_total == 0 && check_count > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask
   task automatic chk(string n, logic [127:0] e, logic [127:0] s);
      check_count++;
      if (e !== s) begin
         err_total++;
         $display("BAD %s expected %h seen %h", n, e, s);
      end
   endtask
   // oldest note against a result; an unexpected result gets kind 99
   task automatic take(int k, logic [127:0] s, logic [15:0] b);
      sfr_note_t n = '{99, '0, '0};
      if (q.size() > 0) n = q.pop_front();
      if (k == 1) for (int i = 0; i < 16; i++) if (!n.b[i]) s[8*i+:8] = 8'h0;
      chk("result kind", 128'(n.k), 128'(k));
      chk("result value", n.v, s);
      chk("byte enables", 128'(n.b), 128'(b));
   endtask
   task automatic note(int k, logic [127:0] v, logic [15:0] b = '0);
      q.push_back('{k, v, b});
   endtask
   task automatic wr(logic [31:0] w, bit rs = 0);
      if (w[31:16] != 0) note(2, '0);
      cw <= w;
      cl <= !rs;
      cr <= rs;
      tick();
      cl <= 0;
      cr <= 0;
      tick();
   endtask
   task automatic rd(logic [31:0] e, bit sa = 0);
      note(0, 128'(e));
      cs <= !sa;
      cv <= sa;
      tick();
      cs <= 0;
      cv <= 0;
   endtask
   task automatic sel(bit l, bit x, logic [2:0] r, bit w = 0);
      lm <= l;
      re <= x;
      rl <= r;
      rw <= w;
      tick();
   endtask
   task automatic vld(sfr_size_t z, bit h, logic [127:0] d);
      lsz <= z;
      lh <= h;
      ld <= d;
      lv <= 1;
      tick();
      lv <= 0;
   endtask
   task automatic vst(sfr_size_t z, bit h, logic [127:0] e, logic [15:0] b);
      note(1, e, b);
      ssz <= z;
      sh <= h;
      stv <= 1;
      tick();
      stv <= 0;
   endtask
   task automatic exc(logic [5:0] f, bit s = 0);
      ef <= f;
      es <= s;
      ev <= 1;
      tick();
      ev <= 0;
      tick();
   endtask

   always @(negedge clk) begin
      if (rstn) begin
         if (crv === 1'b1) take(0, 128'(crd), '0);
         if (vvl === 1'b1) take(1, vd, vbe);
         if (pf === 1'b1) take(2, '0, '0);
         if (sx === 1'b1) take(3, '0, '0);
         if (fz === 1'b1) take(4, 128'(fres), '0);
      end
   end
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc == 3000) begin
         err_total++;
         summarize();
      end
   end
   initial begin
      clk = 0;
      forever #2.5 clk = ~clk;
   end
   initial begin
      logic [127:0] v [16];
      logic [31:0]  w;
      logic [31:0]  opnd [4];
      void'($urandom(32'h2264));
      opnd = '{32'h8000_0123, 32'h0000_0001, 32'h3f80_0000, 32'h8000_0000};
      tick(10);
      rstn <= 1;
      sv <= 1;
      rp <= 1;
      rd(32'h0000_1f80);
      chk("supported mask", 128'(32'h0000_ffff), 128'(smask));
      $display("test reset done");
      for (int i = 0; i < 4; i++) begin
         w = ($urandom() & 32'h0000_9fff) | (i << 13);
         wr(w, i[0]);
         rd(w, i[1]);
         @(negedge clk);
         chk("rounding", 128'(i), 128'(rmode));
         tick();
         wr({16'($urandom_range(65535, 1)), 16'h1f80 ^ 16'(1 << i)}, i[1]);
         rd(w);
      end
      $display("test control word done");
      for (int e = 0; e < 6; e++) begin
         wr(32'h0000_1f80 & ~(32'h80 << e));
         exc(6'h3f ^ 6'(1 << e));
         note(3, '0);
         exc(6'(1 << e));
         exc(6'h00);
         rd((32'h0000_1f80 & ~(32'h80 << e)) | 32'h3f);
      end
      wr(32'h0000_0001);
      wr(32'h0000_9f80);
      note(4, 128'(32'h8000_0000));
      exc(6'h10, 1);
      rd(32'h0000_9fb0);
      wr(32'h0000_9780);
      note(3, '0);
      exc(6'h10, 1);
      rd(32'h0000_9790);
      $display("test exceptions done");
      for (int d = 0; d < 2; d++) begin
         wr(d ? 32'h0000_1ec0 : 32'h0000_1e80);
         if (!d) note(3, '0);
         exc(6'h02);
         rd(d ? 32'h0000_1ec0 : 32'h0000_1e82);
         foreach (opnd[j]) begin
            src <= opnd[j];
            tick();
            @(negedge clk);
            w = (d && opnd[j][30:23] == 0) ? {opnd[j][31], 31'h0} : opnd[j];
            chk("screened operand", 128'(w), 128'(sop));
            tick();
         end
      end
      $display("test denormal zero done");
      rstn <= 0;
      tick(2);
      rstn <= 1;
      rd(32'h0000_1f80);
      $display("test mid-run reset done");
      for (int r = 0; r < 16; r++) begin
         v[r] = {$urandom(), $urandom(), $urandom(), $urandom()};
         sel(1, r[3], r[2:0], r[0]);
         @(negedge clk);
         chk("vector index", 128'(r), 128'(vidx));
         chk("wide gpr", 128'(r[0]), 128'(gw));
         tick();
         vld(SFR_SZ_128, 0, v[r]);
      end
      for (int r = 15; r >= 0; r--) begin
         sel(1, r[3], r[2:0]);
         vst(SFR_SZ_128, 0, v[r], 16'hffff);
      end
      tick(2);
      chk("memory image", v[0], img);
      sel(0, 1, 3'h5, 1);
      @(negedge clk);
      chk("compat index", 128'(5), 128'(vidx));
      chk("compat gpr", 128'(0), 128'(gw));
      tick();
      vst(SFR_SZ_128, 0, v[5], 16'hffff);
      sel(1, 1, 3'h2);
      vld(SFR_SZ_64, 1, v[3]);
      vst(SFR_SZ_64, 1, {64'h0, v[3][63:0]}, 16'h00ff);
      w = $urandom();
      vld(SFR_SZ_32, 0, {v[4][127:32], w});
      vst(SFR_SZ_32, 0, {96'h0, w}, 16'h000f);
      sv <= 0;
      vld(SFR_SZ_128, 0, ~v[10]);
      sv <= 1;
      vst(SFR_SZ_128, 0, {v[3][63:0], v[10][63:32], w}, 16'hffff);
      tick(3);
      $display("test vector registers done");
      chk("pending results", 128'(0), 128'(q.size()));
      summarize();
   end
endmodule
`default_nettype wire
